// ===== sbc_pkg.sv
// Purpose: Shared constants, types and the status decode for the system bus controller.
// Assumes: One clock domain; registers are reached over a 32-bit classic Wishbone slave.
// Notes: Offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package sbc_pkg;

    // Register byte offsets
    localparam logic [7:0] SBC_OFF_CTRL = 8'h00;
    localparam logic [7:0] SBC_OFF_STAT = 8'h04;
    localparam logic [7:0] SBC_OFF_LOG = 8'h08;

    // Control register field positions
    localparam int SBC_CTRL_ADV_WRITE = 0;
    localparam int SBC_CTRL_RESTART_SEVEN_OPCODE_EN = 1;
    localparam int SBC_CTRL_LOG_EN = 2;
    localparam logic [2:0] SBC_CTRL_RESET = 3'h6;

    // Status register field positions
    localparam int SBC_STAT_LAT_LO = 0;
    localparam int SBC_STAT_LOG_VALID = 8;
    localparam int SBC_STAT_LOG_READY = 9;
    localparam int SBC_STAT_DROP_LO = 16;
    localparam int SBC_STAT_CMD_LO = 24;

    // Processor data bus bit positions that carry status
    localparam int SBC_D_INT_ACK_CMD_N = 0;
    localparam int SBC_D_WO_N = 1;
    localparam int SBC_D_HALT_ACK_STATUS = 3;
    localparam int SBC_D_OUT = 4;
    localparam int SBC_D_INP = 6;
    localparam int SBC_D_MEM_READ_CMD_N = 7;

    // Restart-7 opcode driven during an inserted acknowledge read
    localparam logic [7:0] SBC_RESTART_SEVEN_OPCODE = 8'hff;
    localparam logic [7:0] SBC_DROP_MAX = 8'hff;

    // Six latched status bits
    typedef struct packed {
        logic int_ack_cmd_n;
        logic wo_n;
        logic halt_ack_status;
        logic out;
        logic inp;
        logic mem_read_cmd_n;
    } sbc_status_s;

    // One bit per command, active high inside the block
    typedef struct packed {
        logic mem_rd;
        logic mem_wr;
        logic io_rd;
        logic io_wr;
        logic int_ack;
    } sbc_cmd_s;

    // Machine cycle progress
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_LATCHED,
        PH_WRITTEN
    } sbc_phase_e;

    // Which commands the latched status qualifies
    function automatic sbc_cmd_s sbc_decode(input sbc_status_s s);
        sbc_cmd_s c;
        logic halt_only;
        halt_only = s.halt_ack_status & ~s.int_ack_cmd_n;
        c.int_ack = s.int_ack_cmd_n;
        c.mem_rd = s.mem_read_cmd_n & ~halt_only & ~s.int_ack_cmd_n;
        c.mem_wr = ~s.wo_n & ~s.out & ~s.int_ack_cmd_n;
        c.io_rd = s.inp & ~s.int_ack_cmd_n;
        c.io_wr = s.out & ~s.wo_n & ~s.int_ack_cmd_n;
        if (halt_only) begin
            c = '0;
        end
        return c;
    endfunction

endpackage
`default_nettype wire

// ===== sbc_fifo.sv
// Purpose: Small ring buffer with valid/ready on both sides.
// Assumes: Synchronous active-high reset; DEPTH of at least two.
// Notes: Push and pop in one cycle are allowed, also when full.
`timescale 1ns/10ps
`default_nettype none
module sbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

    // Whole state of the buffer
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } sbc_fifo_state_s;

    sbc_fifo_state_s st; // Registered state
    sbc_fifo_state_s next_st; // Next state
    logic push; // Word accepted this cycle
    logic pop; // Word leaves this cycle

    // Valid comes from the fill level; ready also passes when a pop frees a full buffer
    assign in_ready_o = (st.cnt != FULL) | out_ready_i;
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o = st.mem[st.rp];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Pointer and level update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data_i;
            next_st.wp = (st.wp == LAST) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
        end
        if (push & ~pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop & ~push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // sbc_fifo
`default_nettype wire

// ===== sbc_controller.sv
// Purpose: System bus controller between an 8-bit processor and its memory/I/O bus.
// Assumes: All pins synchronous to clk_i; the processor keeps its own bus protocol.
// Notes: Commands are registered, so they follow their cause by one clock.
// Notes on behaviour
// - Six latches hold status each machine cycle.
// - Status captured on falling status strobe.
// - Decode status into memory and I/O commands.
// - Acknowledge from D0; halt alone gives nothing.
// - Reads and acknowledge need input mode active.
// - Writes need the write strobe asserted.
// - Every command output is active low.
// - Each acknowledge cycle of a call gets acknowledge.
// - Strapped acknowledge pin inserts restart-7 opcode.
// - Two 8-bit ports pass bytes bit for bit.
// - Status and bus enable steer the transceiver.
// - System side driven only while enable low.
// - Advanced variant asserts writes earlier.
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sbc_controller
    import sbc_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int LOG_DEPTH = 2,
    parameter bit ADVANCED_WRITE = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Processor control inputs
    input wire logic status_strobe_n_i,
    input wire logic cpu_input_mode_i,
    input wire logic write_strobe_n_i,
    input wire logic hold_ack_in_i,
    input wire logic system_bus_enable_n_i,
    input wire logic restart_strap_i,
    // Processor-side data port
    input wire logic [DATA_W-1:0] cpu_side_data_i,
    output logic [DATA_W-1:0] cpu_side_data_o,
    output logic cpu_side_data_oe_n_o,
    // System-side data port
    input wire logic [DATA_W-1:0] system_side_data_i,
    output logic [DATA_W-1:0] system_side_data_o,
    output logic system_side_data_oe_n_o,
    // Command outputs, active low
    output logic mem_read_cmd_n_o,
    output logic mem_write_cmd_n_o,
    output logic io_read_cmd_n_o,
    output logic io_write_cmd_n_o,
    output logic int_ack_cmd_n_o,
    // Status log back-pressure
    output logic status_log_ready_o,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // Whole state of the controller
    typedef struct packed {
        logic strobe_prev;
        sbc_phase_e phase;
        sbc_status_s status;
        logic wr_seen;
        sbc_cmd_s cmd;
        logic [DATA_W-1:0] cpu_q;
        logic [DATA_W-1:0] sys_q;
        logic [2:0] ctrl;
        logic [7:0] drop_cnt;
        logic ack;
        logic [31:0] rdata;
    } sbc_state_s;

    sbc_state_s st; // Registered state
    sbc_state_s next_st; // Next state
    sbc_status_s captured; // Status byte seen on the processor port
    sbc_cmd_s qual; // Commands the latched status allows
    logic strobe_fall; // Status strobe went low this cycle
    logic cycle_open; // A machine cycle has been latched
    logic adv_mode; // Early write timing in force
    logic insert_restart_seven_opcode; // Restart-7 replaces system data
    logic wr_rise; // Write strobe high again after it was seen low in this cycle
    logic wb_req; // New Wishbone request this cycle
    logic log_push_valid; // Status word offered to the log
    logic log_in_ready; // Log can take a word
    logic log_out_valid; // Log holds a word
    logic log_pop; // Software takes the head word
    logic [7:0] log_head; // Oldest logged status byte

    // Address decode used by the register writes, the read mux and the log pop
    function automatic logic sbc_hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    // Pick the six status bits off the processor port
    always_comb begin
        captured.int_ack_cmd_n = cpu_side_data_i[SBC_D_INT_ACK_CMD_N];
        captured.wo_n = cpu_side_data_i[SBC_D_WO_N];
        captured.halt_ack_status = cpu_side_data_i[SBC_D_HALT_ACK_STATUS];
        captured.out = cpu_side_data_i[SBC_D_OUT];
        captured.inp = cpu_side_data_i[SBC_D_INP];
        captured.mem_read_cmd_n = cpu_side_data_i[SBC_D_MEM_READ_CMD_N];
    end

    // Cycle qualifiers
    assign strobe_fall = st.strobe_prev & ~status_strobe_n_i;
    assign cycle_open = (st.phase != PH_IDLE);
    assign qual = sbc_decode(st.status);
    assign adv_mode = ADVANCED_WRITE | st.ctrl[SBC_CTRL_ADV_WRITE];
    assign wr_rise = st.wr_seen & write_strobe_n_i;
    // An acknowledge read with the strap fitted gets the restart opcode
    // Hold acknowledge suppresses insertion just as it suppresses the command
    assign insert_restart_seven_opcode = restart_strap_i & st.ctrl[SBC_CTRL_RESTART_SEVEN_OPCODE_EN] & ~hold_ack_in_i
        & cycle_open & qual.int_ack & cpu_input_mode_i;

    // Wishbone request and log handshake
    assign wb_req = wb_cyc_i & wb_stb_i & ~st.ack;
    assign log_push_valid = strobe_fall & st.ctrl[SBC_CTRL_LOG_EN];
    assign log_pop = wb_req & ~wb_we_i & sbc_hit(wb_adr_i, SBC_OFF_LOG) & log_out_valid;

    // Two-entry log of status bytes, drained by software
    sbc_fifo #(
        .WIDTH(8),
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(log_push_valid),
        .in_ready_o(log_in_ready),
        .in_data_i(cpu_side_data_i[7:0]),
        .out_valid_o(log_out_valid),
        .out_ready_i(log_pop),
        .out_data_o(log_head)
    );

    // Next-state logic for latches, commands, data and registers
    always_comb begin
        next_st = st;
        next_st.strobe_prev = status_strobe_n_i;

        // Status latches take a fresh word at each cycle start
        if (strobe_fall) begin
            next_st.status = captured;
            next_st.phase = PH_LATCHED;
            next_st.wr_seen = 1'b0;
        end else begin
            // Note a write strobe so its release ends an early write
            if (cycle_open & ~write_strobe_n_i) begin
                next_st.wr_seen = 1'b1;
            end
            if ((st.phase == PH_LATCHED) & wr_rise) begin
                next_st.phase = PH_WRITTEN;
            end
        end

        // Read-type commands need input mode; hold acknowledge blocks them
        next_st.cmd.mem_rd = cycle_open & qual.mem_rd
            & cpu_input_mode_i & ~hold_ack_in_i;
        next_st.cmd.io_rd = cycle_open & qual.io_rd
            & cpu_input_mode_i & ~hold_ack_in_i;
        // Every acknowledge read of a multi-byte call is answered alike
        next_st.cmd.int_ack = cycle_open & qual.int_ack
            & cpu_input_mode_i & ~hold_ack_in_i;

        // Write-type commands: standard waits for the strobe,
        // advanced opens at the latch and closes at strobe release
        if (adv_mode) begin
            next_st.cmd.mem_wr = (st.phase == PH_LATCHED) & qual.mem_wr
                & ~wr_rise & ~strobe_fall;
            next_st.cmd.io_wr = (st.phase == PH_LATCHED) & qual.io_wr
                & ~wr_rise & ~strobe_fall;
        end else begin
            next_st.cmd.mem_wr = cycle_open & qual.mem_wr & ~write_strobe_n_i;
            next_st.cmd.io_wr = cycle_open & qual.io_wr & ~write_strobe_n_i;
        end

        // Data path registers, one byte each way
        if (insert_restart_seven_opcode) begin
            next_st.cpu_q = SBC_RESTART_SEVEN_OPCODE;
        end else begin
            next_st.cpu_q = system_side_data_i;
        end
        next_st.sys_q = cpu_side_data_i;

        // Wishbone: answer one cycle after the request, then drop ack
        next_st.ack = wb_req;
        next_st.rdata = 32'h0000_0000;
        if (wb_req & wb_we_i) begin
            // Writes to the control word only take byte lane 0
            if (sbc_hit(wb_adr_i, SBC_OFF_CTRL) & wb_sel_i[0]) begin
                next_st.ctrl = wb_dat_i[2:0];
            end
            // A write to the status word with byte lane 2 selected clears the drop counter
            if (sbc_hit(wb_adr_i, SBC_OFF_STAT) & wb_sel_i[2]) begin
                next_st.drop_cnt = 8'h00;
            end
        end else if (wb_req) begin
            // Reads; unmapped offsets answer with zero
            if (sbc_hit(wb_adr_i, SBC_OFF_CTRL)) begin
                next_st.rdata[2:0] = st.ctrl;
            end else if (sbc_hit(wb_adr_i, SBC_OFF_STAT)) begin
                next_st.rdata[SBC_STAT_LAT_LO +: 6] = st.status;
                next_st.rdata[SBC_STAT_LOG_VALID] = log_out_valid;
                next_st.rdata[SBC_STAT_LOG_READY] = log_in_ready;
                next_st.rdata[SBC_STAT_DROP_LO +: 8] = st.drop_cnt;
                next_st.rdata[SBC_STAT_CMD_LO +: 5] = st.cmd;
            end else if (sbc_hit(wb_adr_i, SBC_OFF_LOG)) begin
                // Empty log reads as zero with bit 8 clear
                next_st.rdata[7:0] = log_out_valid ? log_head : 8'h00;
                next_st.rdata[8] = log_out_valid;
            end
        end

        // Count status words lost while the log was full; counted after the
        // clear so a drop in the clearing cycle is kept, not lost
        if (log_push_valid & ~log_in_ready & (next_st.drop_cnt != SBC_DROP_MAX)) begin
            next_st.drop_cnt = next_st.drop_cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.strobe_prev <= 1'b1;
            st.phase <= PH_IDLE;
            st.status <= '0;
            st.wr_seen <= 1'b0;
            st.cmd <= '0;
            st.cpu_q <= '0;
            st.sys_q <= '0;
            st.ctrl <= SBC_CTRL_RESET;
            st.drop_cnt <= 8'h00;
            st.ack <= 1'b0;
            st.rdata <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    // Commands leave the block inverted
    assign mem_read_cmd_n_o = ~st.cmd.mem_rd;
    assign mem_write_cmd_n_o = ~st.cmd.mem_wr;
    assign io_read_cmd_n_o = ~st.cmd.io_rd;
    assign io_write_cmd_n_o = ~st.cmd.io_wr;
    assign int_ack_cmd_n_o = ~st.cmd.int_ack;

    // Processor side is driven only in input mode
    assign cpu_side_data_o = st.cpu_q;
    assign cpu_side_data_oe_n_o = ~cpu_input_mode_i;

    // System side: bus enable acts without the clock, so a high level
    // releases the bus at once even mid-cycle
    assign system_side_data_o = st.sys_q;
    assign system_side_data_oe_n_o = system_bus_enable_n_i
        | cpu_input_mode_i | ~cycle_open;

    // Bus and log outputs
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign status_log_ready_o = log_in_ready;

endmodule // sbc_controller
`default_nettype wire

// ===== sbc_controller_assertions.sv
// Purpose: Concurrent checks on the pins of the system bus controller.
// Assumes: Standard write timing; restart enable in control stays set.
// Notes: A local copy of the status capture gives the decode its cause.
`timescale 1ns/10ps
`default_nettype none
module sbc_controller_assertions
    import sbc_pkg::*;
#(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Processor side
    input wire logic status_strobe_n_i,
    input wire logic cpu_input_mode_i,
    input wire logic write_strobe_n_i,
    input wire logic hold_ack_in_i,
    input wire logic restart_strap_i,
    input wire logic [DATA_W-1:0] cpu_side_data_i,
    input wire logic [DATA_W-1:0] cpu_side_data_o,
    input wire logic cpu_side_data_oe_n_o,
    // System side
    input wire logic system_bus_enable_n_i,
    input wire logic [DATA_W-1:0] system_side_data_i,
    input wire logic [DATA_W-1:0] system_side_data_o,
    input wire logic system_side_data_oe_n_o,
    // Commands, active low
    input wire logic mem_read_cmd_n_o,
    input wire logic mem_write_cmd_n_o,
    input wire logic io_read_cmd_n_o,
    input wire logic io_write_cmd_n_o,
    input wire logic int_ack_cmd_n_o
);
    logic strobe_prev; // Strobe level at the last edge
    logic [DATA_W-1:0] seen; // Status byte as captured
    logic [4:0] act; // Commands turned active high
    assign act = ~{mem_read_cmd_n_o, mem_write_cmd_n_o, io_read_cmd_n_o,
        io_write_cmd_n_o, int_ack_cmd_n_o};
    // Capture copy; resets high so a strobe held low through reset counts as a fall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_prev <= 1'b1;
            seen <= '0;
        end else begin
            strobe_prev <= status_strobe_n_i;
            if (strobe_prev && !status_strobe_n_i) begin
                seen <= cpu_side_data_i;
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_read_gate: assert property (
        (act[4] || act[2] || act[0]) |-> $past(cpu_input_mode_i) && !$past(hold_ack_in_i))
        else $error("read command without input mode");
    a_write_gate: assert property (
        (act[3] || act[1]) |-> !$past(write_strobe_n_i))
        else $error("write command without write strobe");
    a_mem_read_cause: assert property (
        act[4] |-> $past(seen[7]) && !$past(seen[0]))
        else $error("memory read without matching status");
    a_io_write_cause: assert property (
        act[1] |-> $past(seen[4]) && !$past(seen[1]))
        else $error("io write without matching status");
    a_ack_alone: assert property (
        act[0] |-> $past(seen[0]) && act[4:1] == 4'h0)
        else $error("acknowledge with wrong status or company");
    a_halt_quiet: assert property (
        $past(seen[3]) && !$past(seen[0]) |-> act == 5'h00)
        else $error("command during halt status");
    a_cpu_direction: assert property (
        cpu_side_data_oe_n_o == !cpu_input_mode_i)
        else $error("processor port direction wrong");
    a_bus_release: assert property (
        system_bus_enable_n_i || cpu_input_mode_i |-> system_side_data_oe_n_o)
        else $error("system bus driven while not allowed");
    a_sys_copy: assert property (
        !$past(rst_i) |-> system_side_data_o == $past(cpu_side_data_i))
        else $error("system side byte differs");
    a_cpu_copy: assert property (
        !$past(rst_i) && int_ack_cmd_n_o |-> cpu_side_data_o == $past(system_side_data_i))
        else $error("processor side byte differs");
    a_restart_ones: assert property (
        !int_ack_cmd_n_o && $past(restart_strap_i) |-> cpu_side_data_o == SBC_RESTART_SEVEN_OPCODE)
        else $error("restart opcode missing");
endmodule // sbc_controller_assertions
bind sbc_controller sbc_controller_assertions #(.DATA_W(DATA_W)) sbc_controller_assertions_i (
    .clk_i(clk_i), .rst_i(rst_i), .status_strobe_n_i(status_strobe_n_i),
    .cpu_input_mode_i(cpu_input_mode_i), .write_strobe_n_i(write_strobe_n_i),
    .hold_ack_in_i(hold_ack_in_i), .restart_strap_i(restart_strap_i),
    .cpu_side_data_i(cpu_side_data_i), .cpu_side_data_o(cpu_side_data_o),
    .cpu_side_data_oe_n_o(cpu_side_data_oe_n_o), .system_bus_enable_n_i(system_bus_enable_n_i),
    .system_side_data_i(system_side_data_i), .system_side_data_o(system_side_data_o),
    .system_side_data_oe_n_o(system_side_data_oe_n_o), .mem_read_cmd_n_o(mem_read_cmd_n_o),
    .mem_write_cmd_n_o(mem_write_cmd_n_o), .io_read_cmd_n_o(io_read_cmd_n_o),
    .io_write_cmd_n_o(io_write_cmd_n_o), .int_ack_cmd_n_o(int_ack_cmd_n_o));
`default_nettype wire

// ===== sbc_cpu_model.sv
// Purpose: Behavioural processor driving status, strobes and data.
// Assumes: Driven from the bench; one machine cycle per call of run.
// Notes: Outside the status slot the data lines carry fresh noise.
`timescale 1ns/10ps
`default_nettype none
module sbc_cpu_model
    import sbc_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Processor pins
    output logic strobe_n_o,
    output logic input_mode_o,
    output logic write_n_o,
    output logic hold_ack_o,
    output logic strap_o,
    output logic [7:0] data_o,
    // Marks the cycle where commands are judged
    output logic probe_o
);
    logic [7:0] status_q; // Byte shown while strobe is low
    logic [7:0] noise; // Changes every cycle so a stale byte never matches
    assign data_o = strobe_n_o ? noise : status_q;
    // Idle levels from time zero
    initial begin
        strobe_n_o = 1'b1;
        input_mode_o = 1'b0;
        write_n_o = 1'b1;
        hold_ack_o = 1'b0;
        strap_o = 1'b0;
        probe_o = 1'b0;
        status_q = 8'h00;
    end
    // New noise byte each edge
    always @(posedge clk_i) begin
        noise <= $urandom;
    end
    // One machine cycle: status slot, then read or write phase
    task automatic run(input logic [7:0] s, input logic hold, input logic strap);
        @(posedge clk_i);
        status_q <= s;
        strobe_n_o <= 1'b0;
        hold_ack_o <= hold;
        strap_o <= strap;
        @(posedge clk_i);
        strobe_n_o <= 1'b1;
        if (s[SBC_D_WO_N]) begin
            input_mode_o <= 1'b1;
        end else begin
            write_n_o <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        probe_o <= 1'b1;
        @(posedge clk_i);
        probe_o <= 1'b0;
        input_mode_o <= 1'b0;
        write_n_o <= 1'b1;
        hold_ack_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule // sbc_cpu_model
`default_nettype wire

// ===== tb_sbc_controller.sv
// Purpose: Self-checking bench for the system bus controller.
// Assumes: Control reset value keeps restart insertion and log on.
// Notes: Drivers queue expectations; monitors pop them as results show.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_sbc_controller;
    import sbc_pkg::*;
    logic clk_i, rst_i, system_bus_enable_n_n, cyc, stb, we, ack, sp;
    logic stb_n, mode, wr_n, hold, strap, probe, cpu_oe_n, sys_oe_n, log_rdy;
    logic [7:0] sys_d, adr, cpu_d, cpu_q, sys_q;
    logic [3:0] sel;
    logic [4:0] cmd_n;
    logic [31:0] wdat, wb_q;
    logic [6:0] e; // {read, insert, commands}
    logic [63:0] w; // {mask, value}
    logic [6:0] exp_q[$];
    logic [63:0] rd_q[$];
    int bad_count, n_compared, cycles;
    // {hold, commands, status}
    logic [13:0] table_c [11] = '{14'h10a2, 14'h1082, 14'h0800, 14'h1086, 14'h0804,
        14'h0442, 14'h0210, 14'h0123, 14'h008a, 14'h012b, 14'h2082};
    sbc_controller sbc_controller_i (.clk_i(clk_i), .rst_i(rst_i), .status_strobe_n_i(stb_n),
        .cpu_input_mode_i(mode), .write_strobe_n_i(wr_n), .hold_ack_in_i(hold),
        .system_bus_enable_n_i(system_bus_enable_n_n), .restart_strap_i(strap), .cpu_side_data_i(cpu_d),
        .cpu_side_data_o(cpu_q), .cpu_side_data_oe_n_o(cpu_oe_n), .system_side_data_i(sys_d),
        .system_side_data_o(sys_q), .system_side_data_oe_n_o(sys_oe_n),
        .mem_read_cmd_n_o(cmd_n[4]), .mem_write_cmd_n_o(cmd_n[3]), .io_read_cmd_n_o(cmd_n[2]),
        .io_write_cmd_n_o(cmd_n[1]), .int_ack_cmd_n_o(cmd_n[0]), .status_log_ready_o(log_rdy),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_q), .wb_ack_o(ack));
    sbc_cpu_model sbc_cpu_model_i (.clk_i(clk_i), .strobe_n_o(stb_n), .input_mode_o(mode),
        .write_n_o(wr_n), .hold_ack_o(hold), .strap_o(strap), .data_o(cpu_d), .probe_o(probe));
    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // System side noise and random bus enable, both reach the pins
    always @(posedge clk_i) begin
        sys_d <= $urandom;
        system_bus_enable_n_n <= $urandom_range(1, 0);
    end
    // Command monitor judges each machine cycle where the model marks it
    always @(negedge clk_i) begin
        if (probe === 1'b1) begin
            e = exp_q.pop_front();
            `CHK(~cmd_n, e[4:0])
            if (e[5]) `CHK(cpu_q, SBC_RESTART_SEVEN_OPCODE)
            if (!e[6]) `CHK(sys_oe_n, system_bus_enable_n_n)
        end
    end
    // Register read monitor compares data on each read acknowledge
    always @(negedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            w = rd_q.pop_front();
            `CHK(wb_q & w[63:32], w[31:0])
        end
    end
    // Hang guard, far above the hundred-odd cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    // Classic single cycle; held until ack is seen high
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(negedge clk_i);
        while (ack !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Read with expected masked value noted first
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        rd_q.push_back({m, v});
        wb(1'b0, a, 32'h0, 4'hf);
    endtask
    // Counts, verdict and end of run
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_i, cyc, stb, we, system_bus_enable_n_n} = 5'h10;
        {adr, sel, wdat, sys_d} = '0;
        {bad_count, n_compared, cycles} = '0;
        void'($urandom(69));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SBC_OFF_CTRL, 32'h7, {29'h0, SBC_CTRL_RESET});
        $display("Control reset test ended");
        foreach (table_c[i]) begin
            sp = $urandom_range(1, 0);
            exp_q.push_back({table_c[i][1], sp & table_c[i][8], table_c[i][12:8]});
            sbc_cpu_model_i.run(table_c[i][7:0], table_c[i][13], sp);
        end
        $display("Decode test ended");
        @(negedge clk_i);
        `CHK(log_rdy, 1'b0)
        rd(SBC_OFF_STAT, 32'h00ff0300, 32'h00090100);
        rd(SBC_OFF_LOG, 32'h1ff, {23'h1, table_c[0][7:0]});
        rd(SBC_OFF_LOG, 32'h1ff, {23'h1, table_c[1][7:0]});
        rd(SBC_OFF_LOG, 32'hffffffff, 32'h0);
        wb(1'b1, SBC_OFF_STAT, 32'h0, 4'h4);
        rd(SBC_OFF_STAT, 32'h00ff0300, 32'h00000200);
        $display("Log buffer test ended");
        wb(1'b1, SBC_OFF_CTRL, 32'h2, 4'h1);
        rd(SBC_OFF_CTRL, 32'h7, 32'h2);
        wb(1'b1, 8'h0c, 32'hffffffff, 4'hf);
        rd(8'h0c, 32'hffffffff, 32'h0);
        $display("Register access test ended");
        wb(1'b1, SBC_OFF_CTRL, 32'h7, 4'h1);
        exp_q.push_back({2'b00, 5'h08});
        sbc_cpu_model_i.run(8'h00, 1'b0, 1'b0);
        $display("Advanced write test ended");
        repeat (2) @(posedge clk_i);
        wrap_up();
    end
endmodule // tb_sbc_controller
`default_nettype wire
